// *** include/rtcac_cfg.svh ***
// offsets, field codes, reset values and counts of the alarm comparator
// Notes on behaviour
// - latch and counter values are BCD bytes
// - latch value 204 means don't care
// - don't care field matches every counter value
// - control value 1 enables latch alarm
// - reading status clears its pending bits
// - status shows alarm when all fields newly match and control enables the alarm
// - day of week counts Sunday as 1
// - month counts January as 1
// - index port, then data two above
// - control at index 17, status 16
`ifndef RTCAC_CFG_SVH
`define RTCAC_CFG_SVH

// avalon byte addresses (index times four)
`define RTCAC_PORT_INDEX_IDX   4'h0
`define RTCAC_PORT_DATA_IDX    4'h2
`define RTCAC_ADDR_INDEX       6'h00
`define RTCAC_ADDR_DATA        6'h08

// internal register indices
`define RTCAC_IDX_CNT_FIRST    5'h02
`define RTCAC_IDX_CNT_LAST     5'h07
`define RTCAC_IDX_LATCH_FIRST  5'h0a
`define RTCAC_IDX_LATCH_LAST   5'h0f
`define RTCAC_IDX_STATUS       5'h10
`define RTCAC_IDX_CONTROL      5'h11

`define RTCAC_DONT_CARE        8'hcc
`define RTCAC_LATCH_RST        8'h00
`define RTCAC_CTRL_RST         8'h00
`define RTCAC_STATUS_RST       8'h00
`define RTCAC_INDEX_RST        5'h00
`define RTCAC_ALARM_BIT        0
`define RTCAC_NUM_FIELDS       6
`define RTCAC_DATA_W           8

`endif

// *** include/rtcac_pkg.sv ***
// types shared by the alarm comparator modules
package rtcac_pkg;

  typedef enum logic [1:0]
  {
    RTCAC_IDLE = 2'b01,
    RTCAC_ACK  = 2'b10
  } rtcac_bus_state_type;

  // field order of latches and counters, lowest byte first
  typedef enum logic [2:0]
  {
    RTCAC_F_SEC   = 3'h0,
    RTCAC_F_MIN   = 3'h1,
    RTCAC_F_HOUR  = 3'h2,
    RTCAC_F_DOW   = 3'h3,
    RTCAC_F_DATE  = 3'h4,
    RTCAC_F_MONTH = 3'h5
  } rtcac_field_type;

endpackage

// *** include/rtcac_core_if.sv ***
// links the bus front end to the comparator and the interrupt logic
`timescale 1ns/1ps
`default_nettype none
interface rtcac_core_if;
  logic                        latch_we;
  rtcac_pkg::rtcac_field_type  field_sel;
  logic [7:0]                  wdata;
  logic [47:0]                 latch_q;
  logic                        match;
  logic                        ctrl_we;
  logic [7:0]                  ctrl_q;
  logic [7:0]                  status_q;
  logic [7:0]                  status_clr;
  logic                        irq_next;

  modport top
  (
    output latch_we, field_sel, wdata, ctrl_we, status_clr,
    input  latch_q, match, ctrl_q, status_q, irq_next
  );
  modport cmp
  (
    input  latch_we, field_sel, wdata,
    output latch_q, match
  );
  modport irq
  (
    input  ctrl_we, wdata, status_clr, match,
    output ctrl_q, status_q, irq_next
  );
endinterface
`default_nettype wire

// *** verilog/rtcac_compare.sv ***
// alarm latches and the field-by-field compare against the counters
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_cfg.svh"
module rtcac_compare #(
  parameter int NUM_FIELDS = `RTCAC_NUM_FIELDS
) (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic [47:0] count_i,
  rtcac_core_if.cmp        core
);

  initial
  begin
    if (NUM_FIELDS != 6)
      $error("rtcac_compare serves exactly six fields");
  end

  logic [7:0]            latch_reg [NUM_FIELDS];
  logic [NUM_FIELDS-1:0] hit;
  logic                  match_reg;

  // raw byte compare: both sides are bcd, so no conversion here
  function automatic logic field_hit(input logic [7:0] latch, input logic [7:0] count);
    field_hit = (latch == `RTCAC_DONT_CARE) || (latch == count);
  endfunction

  genvar g;
  generate
    for (g = 0; g < NUM_FIELDS; g = g + 1)
    begin : gen_field
      always_ff @(posedge mclk_i)
      begin
        if (srst_i)
          latch_reg[g] <= `RTCAC_LATCH_RST;
        else if (core.latch_we && (core.field_sel == 3'(g)))
          latch_reg[g] <= core.wdata;
      end
      assign hit[g]                 = field_hit(latch_reg[g], count_i[8*g +: 8]);
      assign core.latch_q[8*g +: 8] = latch_reg[g];
    end
  endgenerate

  // registered so the edge detect downstream sees a clean level
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      match_reg <= 1'b0;
    else
      match_reg <= &hit;
  end

  assign core.match = match_reg;

endmodule
`default_nettype wire

// *** verilog/rtcac_irq.sv ***
// interrupt control, sticky status and interrupt level
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_cfg.svh"
module rtcac_irq (
  input  wire logic mclk_i,
  input  wire logic srst_i,
  rtcac_core_if.irq core
);

  logic [7:0] ctrl_reg;
  logic [7:0] status_reg;
  logic [7:0] status_next;
  logic [7:0] set_bits;
  logic       match_prev_reg;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      ctrl_reg <= `RTCAC_CTRL_RST;
    else if (core.ctrl_we)
      ctrl_reg <= core.wdata;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      match_prev_reg <= 1'b0;
    else
      match_prev_reg <= core.match;
  end

  // only a fresh match counts, so a match that lasts a second fires once
  always_comb
  begin
    set_bits                  = 8'h00;
    set_bits[`RTCAC_ALARM_BIT] = core.match && !match_prev_reg
                                 && ctrl_reg[`RTCAC_ALARM_BIT];
    // clear only what the read reported; a new set wins
    status_next = (status_reg & ~core.status_clr) | set_bits;
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      status_reg <= `RTCAC_STATUS_RST;
    else
      status_reg <= status_next;
  end

  assign core.ctrl_q   = ctrl_reg;
  assign core.status_q = status_reg;
  assign core.irq_next = |(status_next & ctrl_reg);

endmodule
`default_nettype wire

// *** verilog/rtcac_top.sv ***
// avalon slave with indexed port pair in front of the alarm comparator
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_cfg.svh"
module rtcac_top (
  input  wire logic        mclk_i,
  input  wire logic        srst_i,
  input  wire logic [5:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  input  wire logic [3:0]  avs_byteenable_i,
  output logic [31:0]      avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic [7:0]  cnt_sec_i,
  input  wire logic [7:0]  cnt_min_i,
  input  wire logic [7:0]  cnt_hour_i,
  input  wire logic [7:0]  cnt_dow_i,
  input  wire logic [7:0]  cnt_date_i,
  input  wire logic [7:0]  cnt_month_i,
  output logic             irq_o,
  output logic             alarm_match_o
);

  rtcac_core_if core ();

  rtcac_pkg::rtcac_bus_state_type state_reg;
  logic [4:0]  index_reg;
  logic [7:0]  rd_byte;
  logic [7:0]  rd_clr_reg;
  logic [31:0] readdata_reg;
  logic        waitrequest_reg;
  logic        irq_reg;
  logic        alarm_match_reg;
  logic [47:0] count;
  logic        take;
  logic        wr_ok;
  logic        hit_index;
  logic        hit_data;

  // day of week counts from 1 = Sunday, month from 1 = January
  assign count = {cnt_month_i, cnt_date_i, cnt_dow_i,
                  cnt_hour_i, cnt_min_i, cnt_sec_i};

  function automatic logic in_range(input logic [4:0] idx, input logic [4:0] lo,
                                    input logic [4:0] hi);
    in_range = (idx >= lo) && (idx <= hi);
  endfunction

  // read value of the selected internal register
  always_comb
  begin
    rd_byte = 8'h00;
    if (in_range(index_reg, `RTCAC_IDX_CNT_FIRST, `RTCAC_IDX_CNT_LAST))
      rd_byte = count[8*(index_reg - `RTCAC_IDX_CNT_FIRST) +: 8];
    else if (in_range(index_reg, `RTCAC_IDX_LATCH_FIRST, `RTCAC_IDX_LATCH_LAST))
      rd_byte = core.latch_q[8*(index_reg - `RTCAC_IDX_LATCH_FIRST) +: 8];
    else if (index_reg == `RTCAC_IDX_STATUS)
      rd_byte = core.status_q;
    else if (index_reg == `RTCAC_IDX_CONTROL)
      rd_byte = core.ctrl_q;
  end

  assign hit_index = (avs_address_i == `RTCAC_ADDR_INDEX);
  assign hit_data  = (avs_address_i == `RTCAC_ADDR_DATA);
  assign take      = (state_reg == rtcac_pkg::RTCAC_ACK);
  assign wr_ok     = take && avs_write_i && avs_byteenable_i[0];

  // one wait cycle, then the request is taken on the acknowledge edge
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      state_reg <= rtcac_pkg::RTCAC_IDLE;
    else
    begin
      case (state_reg)
        rtcac_pkg::RTCAC_IDLE:
          if (avs_read_i || avs_write_i)
            state_reg <= rtcac_pkg::RTCAC_ACK;
        rtcac_pkg::RTCAC_ACK:
          state_reg <= rtcac_pkg::RTCAC_IDLE;
        default:
          state_reg <= rtcac_pkg::RTCAC_IDLE;
      endcase
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      waitrequest_reg <= 1'b1;
    else
      waitrequest_reg <= !((state_reg == rtcac_pkg::RTCAC_IDLE)
                           && (avs_read_i || avs_write_i));
  end

  // data and the bits it reported are captured together
  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      readdata_reg <= 32'h0000_0000;
      rd_clr_reg   <= 8'h00;
    end
    else if ((state_reg == rtcac_pkg::RTCAC_IDLE) && avs_read_i)
    begin
      if (hit_index)
        readdata_reg <= {27'h0000000, index_reg};
      else if (hit_data)
        readdata_reg <= {24'h000000, rd_byte};
      else
        readdata_reg <= 32'h0000_0000;
      rd_clr_reg <= (hit_data && index_reg == `RTCAC_IDX_STATUS) ? core.status_q : 8'h00;
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
      index_reg <= `RTCAC_INDEX_RST;
    else if (wr_ok && hit_index)
      index_reg <= avs_writedata_i[4:0];
  end

  assign core.wdata      = avs_writedata_i[7:0];
  assign core.latch_we   = wr_ok && hit_data
                           && in_range(index_reg, `RTCAC_IDX_LATCH_FIRST, `RTCAC_IDX_LATCH_LAST);
  assign core.field_sel  = rtcac_pkg::rtcac_field_type'(3'(index_reg - `RTCAC_IDX_LATCH_FIRST));
  assign core.ctrl_we    = wr_ok && hit_data && (index_reg == `RTCAC_IDX_CONTROL);
  // side effect lands on the edge that completes the read
  assign core.status_clr = (take && avs_read_i) ? rd_clr_reg : 8'h00;

  always_ff @(posedge mclk_i)
  begin
    if (srst_i)
    begin
      irq_reg         <= 1'b0;
      alarm_match_reg <= 1'b0;
    end
    else
    begin
      irq_reg         <= core.irq_next;
      alarm_match_reg <= core.match;
    end
  end

  rtcac_compare #(
    .NUM_FIELDS (`RTCAC_NUM_FIELDS)
  ) u_compare (
    .mclk_i  (mclk_i),
    .srst_i  (srst_i),
    .count_i (count),
    .core    (core.cmp)
  );

  rtcac_irq u_irq (
    .mclk_i (mclk_i),
    .srst_i (srst_i),
    .core   (core.irq)
  );

  assign avs_readdata_o    = readdata_reg;
  assign avs_waitrequest_o = waitrequest_reg;
  assign irq_o             = irq_reg;
  assign alarm_match_o     = alarm_match_reg;

endmodule
`default_nettype wire

// *** bench/rtcac_top_checker.sv ***
// concurrent checks on the ports of the alarm comparator top
`timescale 1ns/1ps
`default_nettype none
module rtcac_top_checker (
  input wire logic        mclk_i,
  input wire logic        srst_i,
  input wire logic [5:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_readdata_o,
  input wire logic        avs_waitrequest_o,
  input wire logic        irq_o,
  input wire logic        alarm_match_o
);
  default clocking cb @(posedge mclk_i); endclocking
  default disable iff (srst_i);
  logic acc;
  assign acc = !avs_waitrequest_o;
  a_wait_one_cycle: assert property (acc |=> !acc) else $error("accept too long");
  a_req_answered: assert property ((avs_read_i || avs_write_i) && !acc |=> acc)
    else $error("request not answered");
  a_idle_no_ack: assert property (!avs_read_i && !avs_write_i |=> !acc)
    else $error("accept without request");
  a_read_upper_zero: assert property (avs_readdata_o[31:8] == 24'h0)
    else $error("upper read data set");
  a_unmapped_zero: assert property (acc && avs_read_i && avs_address_i != 6'h00
    && avs_address_i != 6'h08 |-> avs_readdata_o == 32'h0) else $error("unmapped read");
  // irq and match flops load on the same edge when a fresh match sets status
  a_irq_after_match: assert property ($rose(irq_o) |-> alarm_match_o
    || $past(acc && avs_write_i) || $past(acc && avs_write_i, 2))
    else $error("irq without match");
  a_irq_sticky: assert property ($fell(irq_o)
    |-> $past(acc) || $past(acc, 2)) else $error("irq dropped without access");
  a_irq_low_reset: assert property ($past(srst_i) |-> !irq_o && !alarm_match_o)
    else $error("outputs not cleared by reset");
endmodule
bind rtcac_top rtcac_top_checker i_rtcac_top_checker (.mclk_i(mclk_i), .srst_i(srst_i),
  .avs_address_i(avs_address_i), .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
  .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
  .irq_o(irq_o), .alarm_match_o(alarm_match_o));
`default_nettype wire

// *** bench/rtcac_host.sv ***
// host bus master model: index port then data port
`timescale 1ns/1ps
`default_nettype none
`include "rtcac_cfg.svh"
module rtcac_host (
  input wire logic         mclk_i,
  output logic [5:0]       avs_address_o,
  output logic             avs_read_o,
  output logic             avs_write_o,
  output logic [31:0]      avs_writedata_o,
  output logic [3:0]       avs_byteenable_o,
  input wire logic [31:0]  avs_readdata_i,
  input wire logic         avs_waitrequest_i
);
  initial {avs_address_o, avs_read_o, avs_write_o, avs_writedata_o, avs_byteenable_o} = '0;
  // called right after a rising edge; released lines show inverted data
  task automatic xfer(input logic [5:0] a, input logic w, input logic [7:0] d,
                      input logic [3:0] be, output logic [7:0] q);
    avs_address_o <= a;
    avs_write_o <= w;
    avs_read_o <= !w;
    avs_writedata_o <= {24'h0, d};
    avs_byteenable_o <= be;
    @(posedge mclk_i);
    while (avs_waitrequest_i) @(posedge mclk_i);
    q = avs_readdata_i[7:0];
    avs_read_o <= 1'b0;
    avs_write_o <= 1'b0;
    avs_writedata_o <= ~{24'h0, d};
    avs_address_o <= ~a;
    // one idle edge, so a following call never re-raises a strobe in this step
    @(posedge mclk_i);
  endtask
  // values handed in are already bcd
  task automatic reg_wr(input logic [4:0] idx, input logic [7:0] v);
    logic [7:0] q;
    xfer(`RTCAC_ADDR_INDEX, 1'b1, {3'h0, idx}, 4'hf, q);
    xfer(`RTCAC_ADDR_DATA, 1'b1, v, 4'hf, q);
  endtask
  task automatic reg_rd(input logic [4:0] idx, output logic [7:0] q);
    xfer(`RTCAC_ADDR_INDEX, 1'b1, {3'h0, idx}, 4'hf, q);
    xfer(`RTCAC_ADDR_DATA, 1'b0, 8'h00, 4'hf, q);
  endtask
endmodule
`default_nettype wire

// *** bench/rtcac_alarm_comparator_bench.sv ***
// self-checking bench for the alarm comparator
`timescale 1ns/1ps
`default_nettype none
module rtcac_alarm_comparator_bench;
  logic mclk_i = 1'b0;
  logic srst_i = 1'b1;
  logic [47:0] cnt = 48'h0;
  logic [5:0] adr;
  logic rd, wr, wq, irq, mt;
  logic [31:0] wd, rdat;
  logic [3:0] be;
  logic [7:0] q;
  int error_cnt = 0;
  int cmp_count = 0;
  // month 05 date 17 dow 01 hour 12 min 30 sec 45
  localparam logic [47:0] L = 48'h05_17_01_12_30_45;
  initial forever #12.5 mclk_i = ~mclk_i;
  rtcac_host i_rtcac_host (.mclk_i(mclk_i), .avs_address_o(adr), .avs_read_o(rd),
    .avs_write_o(wr), .avs_writedata_o(wd), .avs_byteenable_o(be),
    .avs_readdata_i(rdat), .avs_waitrequest_i(wq));
  rtcac_top i_rtcac_top (.mclk_i(mclk_i), .srst_i(srst_i), .avs_address_i(adr),
    .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(be),
    .avs_readdata_o(rdat), .avs_waitrequest_o(wq), .cnt_sec_i(cnt[7:0]),
    .cnt_min_i(cnt[15:8]), .cnt_hour_i(cnt[23:16]), .cnt_dow_i(cnt[31:24]),
    .cnt_date_i(cnt[39:32]), .cnt_month_i(cnt[47:40]), .irq_o(irq), .alarm_match_o(mt));
  task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
    cmp_count++;
    if (s !== e)
    begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", n, e, s);
    end
  endtask
  // counters change at an edge; match follows one cycle later, status and irq two; five cycles are waited
  task automatic set_cnt(input logic [47:0] v);
    cnt <= v;
    repeat (5) @(posedge mclk_i);
  endtask
  task automatic t_alarm;
    for (int i = 0; i < 6; i++) i_rtcac_host.reg_wr(5'(10 + i), L[i*8 +: 8]);
    i_rtcac_host.reg_rd(5'd15, q); chk("month latch", q, 8'h05);
    i_rtcac_host.reg_rd(5'd13, q); chk("dow latch", q, 8'h01);
    set_cnt(L ^ 48'h1);
    i_rtcac_host.reg_wr(5'd17, 8'h01);
    i_rtcac_host.reg_rd(5'd16, q); chk("status cleared", q, 8'h00);
    set_cnt(L);
    chk("irq on match", irq, 1'b1);
    repeat (6) @(posedge mclk_i);
    chk("irq held", irq, 1'b1);
    i_rtcac_host.reg_rd(5'd16, q); chk("status alarm", q, 8'h01);
    repeat (3) @(posedge mclk_i);
    chk("irq after read", irq, 1'b0);
    i_rtcac_host.reg_rd(5'd16, q); chk("status after read", q, 8'h00);
    $display("test alarm done");
  endtask
  task automatic t_dont_care;
    i_rtcac_host.reg_wr(5'd10, 8'hcc);
    set_cnt(L ^ 48'h100);
    chk("no match", mt, 1'b0);
    set_cnt({L[47:8], 8'h59});
    chk("match any second", mt, 1'b1);
    i_rtcac_host.reg_rd(5'd16, q); chk("status dont care", q, 8'h01);
    $display("test dont care done");
  endtask
  task automatic t_masked;
    i_rtcac_host.reg_wr(5'd17, 8'h00);
    set_cnt(L ^ 48'h100);
    set_cnt(L);
    chk("masked irq", irq, 1'b0);
    i_rtcac_host.reg_rd(5'd17, q); chk("control", q, 8'h00);
    $display("test masked done");
  endtask
  task automatic t_map;
    i_rtcac_host.reg_rd(5'd2, q); chk("sec counter", q, 8'h45);
    i_rtcac_host.xfer(6'h00, 1'b0, 8'h00, 4'hf, q); chk("index back", q, 8'h02);
    i_rtcac_host.xfer(6'h04, 1'b0, 8'h00, 4'hf, q); chk("unmapped", q, 8'h00);
    i_rtcac_host.xfer(6'h00, 1'b1, 8'h11, 4'hf, q);
    i_rtcac_host.xfer(6'h08, 1'b1, 8'h01, 4'he, q); // no low lane, dropped
    i_rtcac_host.reg_rd(5'd17, q); chk("lane off write", q, 8'h00);
    $display("test map done");
  endtask
  // reset in mid-run must drop the match and wipe the latches
  task automatic t_reset;
    srst_i <= 1'b1;
    repeat (3) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    chk("match after reset", mt, 1'b0);
    chk("irq after reset", irq, 1'b0);
    i_rtcac_host.reg_rd(5'd15, q); chk("month latch reset", q, 8'h00);
    i_rtcac_host.reg_rd(5'd17, q); chk("control reset", q, 8'h00);
    $display("test reset done");
  endtask
  task automatic end_sim;
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  initial
  begin
    repeat (10) @(posedge mclk_i);
    srst_i <= 1'b0;
    @(posedge mclk_i);
    chk("irq reset", irq, 1'b0);
    i_rtcac_host.reg_rd(5'd16, q); chk("status reset", q, 8'h00);
    t_alarm;
    t_dont_care;
    t_masked;
    t_map;
    t_reset;
    end_sim;
  end
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    error_cnt++;
    end_sim;
  end
endmodule
`default_nettype wire
